// ==== bal_pkg.sv ====
package bal_pkg;

	// ----------------------------------------------------------------
	// bus map (byte addresses, one aligned 32-bit word per register)
	// ----------------------------------------------------------------
	localparam int          ADDR_W        = 10;
	localparam logic [9:0]  OFFS_CTRL     = 10'h000;
	localparam logic [9:0]  OFFS_STATUS   = 10'h004;
	localparam logic [9:0]  OFFS_RESULT   = 10'h008;
	localparam logic [2:0]  REGF_PAGE     = 3'h1;   // address[9:7]: regfile window at 0x080..0x0FC

	// ----------------------------------------------------------------
	// control word fields
	// ----------------------------------------------------------------
	localparam int OP_LSB   = 0;
	localparam int OP_MSB   = 4;
	localparam int RD_LSB   = 8;
	localparam int RD_MSB   = 12;
	localparam int SRC_LSB  = 16;
	localparam int SRC_MSB  = 20;
	localparam int IMM_LSB  = 24;
	localparam int IMM_MSB  = 31;
	localparam int OPV_BIT  = 31;   // status: last control word carried an unknown opcode

	// ----------------------------------------------------------------
	// status flag positions and reset values
	// ----------------------------------------------------------------
	localparam int         FLAG_C     = 0;
	localparam int         FLAG_Z     = 1;
	localparam int         FLAG_N     = 2;
	localparam int         FLAG_V     = 3;
	localparam int         FLAG_S     = 4;
	localparam int         FLAG_H     = 5;
	localparam logic [7:0] SREG_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [7:0] BYTE_ONES  = 8'hFF;
	localparam logic [7:0] BYTE_ONE   = 8'h01;

	// ----------------------------------------------------------------
	// operations
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_ADD_REGS            = 5'h00,
		OP_ADD_REGS_WITH_CARRY = 5'h01,
		OP_ADD_IMM_TO_PAIR     = 5'h02,
		OP_SUB_REGS            = 5'h03,
		OP_SUB_IMM             = 5'h04,
		OP_SUB_REGS_WITH_BORROW = 5'h05,
		OP_SUB_IMM_WITH_BORROW = 5'h06,
		OP_SUB_IMM_FROM_PAIR   = 5'h07,
		OP_AND_REGS            = 5'h08,
		OP_AND_IMM             = 5'h09,
		OP_OR_REGS             = 5'h0A,
		OP_OR_IMM              = 5'h0B,
		OP_XOR_REGS            = 5'h0C,
		OP_ONES_COMPLEMENT     = 5'h0D,
		OP_TWOS_COMPLEMENT     = 5'h0E,
		OP_SET_MASK_BITS       = 5'h0F,
		OP_CLEAR_MASK_BITS     = 5'h10,
		OP_INCREMENT           = 5'h11,
		OP_DECREMENT           = 5'h12,
		OP_TEST_ZERO_MINUS     = 5'h13,
		OP_CLEAR_REG           = 5'h14
	} bal_op_t;
	localparam logic [4:0] OP_LAST = 5'h14;

	// execution sequencer, gray along idle -> fetch -> exec -> exec_hi
	typedef enum logic [1:0] {
		EX_IDLE    = 2'h0,
		EX_FETCH   = 2'h1,
		EX_EXEC    = 2'h3,
		EX_EXEC_HI = 2'h2
	} bal_ex_state_t;

	// bus slave sequencer, gray along idle -> read -> ack
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_READ = 2'h1,
		BUS_ACK  = 2'h3
	} bal_bus_state_t;

	// ----------------------------------------------------------------
	// 8-bit adder with borrow form: returns {h, v, c, r[7:0]}
	// ----------------------------------------------------------------
	function automatic logic [10:0] bal_add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin, input logic sub);
		logic [7:0] bb;
		logic       ci;
		logic [4:0] lo;
		logic [8:0] full;
		logic       v;
		bb   = sub ? ~b : b;
		ci   = cin ^ sub;
		lo   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		v    = (a[7] == bb[7]) && (full[7] != a[7]);
		return {lo[4] ^ sub, v, full[8] ^ sub, full[7:0]};
	endfunction : bal_add8

endpackage : bal_pkg

// ==== bal_regfile.sv ====
`timescale 1ns/1ps
module bal_regfile
	import bal_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic [4:0] ra_addr_i,
	output logic      [7:0] ra_data_o,
	input  wire logic [4:0] rb_addr_i,
	output logic      [7:0] rb_data_o,
	input  wire logic       we_i,
	input  wire logic [4:0] wa_i,
	input  wire logic [7:0] wd_i
);

	// ----------------------------------------------------------------
	// 32 x 8 working registers
	// ----------------------------------------------------------------
	logic [7:0] mem [0:31];

	// write port; no reset so it maps onto plain storage
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[wa_i] <= wd_i;
		end
	end

	// two registered read ports, old data on a same-cycle write
	always_ff @(posedge clk_i)
	begin
		ra_data_o <= mem[ra_addr_i];
		rb_data_o <= mem[rb_addr_i];
	end

endmodule : bal_regfile

// ==== bal_byte_alu.sv ====
`timescale 1ns/1ps
// Operation
// RULE1: add or add-with-carry, one clock, ZCNVH
// RULE2: add immediate to register pair, two clocks
// RULE3: subtract immediate or register, one clock, ZCNVH
// RULE4: subtract register and carry, one clock
// RULE5: subtract immediate and carry, one clock
// RULE6: subtract immediate from pair, two clocks
// RULE7: AND register or immediate, ZNV only
// RULE8: OR register or immediate, ZNV only
// RULE9: set mask bits by OR, ZNV only
// RULE10: clear mask bits by AND-not, ZNV only
// RULE11: test keeps value, sets ZNV
// RULE12: xor, clear, increment, decrement: ZNV only
// RULE13: one's ZCNV, two's ZCNVH, one clock
module bal_byte_alu
	import bal_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [9:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bal_bus_state_t bus_state;
	bal_ex_state_t  ex_state;
	bal_op_t        op_code;
	logic [4:0]     op_rd;
	logic [4:0]     op_src;
	logic [7:0]     op_imm;
	logic           op_bad;
	logic [7:0]     sreg;
	logic [15:0]    result;
	logic           pair_carry;
	logic           pair_lo_zero;
	logic [4:0]     ra_addr;
	logic [4:0]     rb_addr;
	logic [7:0]     ra_data;
	logic [7:0]     rb_data;
	logic           rf_we;
	logic [4:0]     rf_wa;
	logic [7:0]     rf_wd;
	logic           take;
	logic           in_regf;
	logic           is_pair;
	logic           uses_imm;
	logic [7:0]     opnd_b;
	logic [7:0]     add_x;
	logic [7:0]     add_y;
	logic           add_cin;
	logic           add_sub;
	logic [10:0]    sum;
	logic [7:0]     next_val;
	logic [7:0]     next_sreg;
	logic           next_we;

	// request accepted only while the sequencer is idle, so bus and
	// execution never fight over the register file ports
	assign take    = (bus_state == BUS_IDLE) && (ex_state == EX_IDLE) && (read_i || write_i);
	assign in_regf = (address_i[9:7] == REGF_PAGE);
	assign is_pair = (op_code == OP_ADD_IMM_TO_PAIR) || (op_code == OP_SUB_IMM_FROM_PAIR);

	// ----------------------------------------------------------------
	// register file and its port steering
	// ----------------------------------------------------------------
	// pair ops read the even low byte on port a and the odd high byte on b
	always_comb
	begin
		ra_addr = address_i[6:2];
		rb_addr = op_src;
		if (ex_state != EX_IDLE)
		begin
			ra_addr = is_pair ? {op_rd[4:1], 1'b0} : op_rd;
			rb_addr = is_pair ? {op_rd[4:1], 1'b1} : op_src;
		end
	end

	// execution writes win; bus writes only land while idle
	always_comb
	begin
		rf_we = 1'b0;
		rf_wa = address_i[6:2];
		rf_wd = writedata_i[7:0];
		if (ex_state == EX_EXEC || ex_state == EX_EXEC_HI)
		begin
			rf_we = next_we;
			rf_wa = (ex_state == EX_EXEC_HI) ? {op_rd[4:1], 1'b1} : ra_addr;
			rf_wd = next_val;
		end
		else if (take && write_i && in_regf)
		begin
			rf_we = 1'b1;
		end
	end

	bal_regfile u_regfile (
		.clk_i     (clk_i),
		.ra_addr_i (ra_addr),
		.ra_data_o (ra_data),
		.rb_addr_i (rb_addr),
		.rb_data_o (rb_data),
		.we_i      (rf_we),
		.wa_i      (rf_wa),
		.wd_i      (rf_wd)
	);

	// ----------------------------------------------------------------
	// adder operand selection
	// ----------------------------------------------------------------
	always_comb
	begin
		case (op_code)
			OP_SUB_IMM, OP_SUB_IMM_WITH_BORROW, OP_AND_IMM, OP_OR_IMM,
			OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS:
				uses_imm = 1'b1;
			default:
				uses_imm = 1'b0;
		endcase
	end
	assign opnd_b = uses_imm ? op_imm : rb_data;

	// one shared adder serves every add, subtract and count
	always_comb
	begin
		add_x   = ra_data;
		add_y   = opnd_b;
		add_cin = 1'b0;
		add_sub = 1'b0;
		case (op_code)
			OP_ADD_REGS_WITH_CARRY:
				add_cin = sreg[FLAG_C];                              // [RULE1]
			OP_SUB_REGS, OP_SUB_IMM:
				add_sub = 1'b1;                                      // [RULE3]
			OP_SUB_REGS_WITH_BORROW, OP_SUB_IMM_WITH_BORROW:
			begin
				add_sub = 1'b1;                                      // [RULE4] [RULE5]
				add_cin = sreg[FLAG_C];
			end
			OP_TWOS_COMPLEMENT:
			begin
				add_x   = BYTE_ZERO;                                 // [RULE13]
				add_y   = ra_data;
				add_sub = 1'b1;
			end
			OP_INCREMENT:
				add_y = BYTE_ONE;                                    // [RULE12]
			OP_DECREMENT:
			begin
				add_y   = BYTE_ONE;                                  // [RULE12]
				add_sub = 1'b1;
			end
			OP_ADD_IMM_TO_PAIR, OP_SUB_IMM_FROM_PAIR:
			begin
				add_sub = (op_code == OP_SUB_IMM_FROM_PAIR);         // [RULE2] [RULE6]
				add_y   = op_imm;
				if (ex_state == EX_EXEC_HI)
				begin
					// high byte only ripples the low-byte carry or borrow
					add_x   = rb_data;
					add_y   = BYTE_ZERO;
					add_cin = pair_carry;
				end
			end
			default:
			begin
				add_x = ra_data;
			end
		endcase
	end
	assign sum = bal_add8(add_x, add_y, add_cin, add_sub);

	// ----------------------------------------------------------------
	// result and flags; flags not named by an op keep their value
	// ----------------------------------------------------------------
	always_comb
	begin
		next_val  = sum[7:0];
		next_sreg = sreg;
		next_we   = 1'b1;
		case (op_code)
			OP_ADD_REGS, OP_ADD_REGS_WITH_CARRY, OP_SUB_REGS, OP_SUB_IMM,
			OP_SUB_REGS_WITH_BORROW, OP_SUB_IMM_WITH_BORROW, OP_TWOS_COMPLEMENT:
			begin
				next_sreg[FLAG_Z] = (sum[7:0] == BYTE_ZERO);         // [RULE1] [RULE3] [RULE4] [RULE5]
				next_sreg[FLAG_C] = sum[8];
				next_sreg[FLAG_N] = sum[7];
				next_sreg[FLAG_V] = sum[9];
				next_sreg[FLAG_H] = sum[10];                         // [RULE13]
			end
			OP_ADD_IMM_TO_PAIR, OP_SUB_IMM_FROM_PAIR:
			begin
				// word flags are only settled once the high byte is done
				if (ex_state == EX_EXEC_HI)
				begin
					next_sreg[FLAG_Z] = pair_lo_zero && (sum[7:0] == BYTE_ZERO); // [RULE2] [RULE6]
					next_sreg[FLAG_C] = sum[8];
					next_sreg[FLAG_N] = sum[7];
					next_sreg[FLAG_V] = sum[9];
					next_sreg[FLAG_S] = sum[7] ^ sum[9];
				end
			end
			OP_INCREMENT, OP_DECREMENT:
			begin
				next_sreg[FLAG_Z] = (sum[7:0] == BYTE_ZERO);         // [RULE12]
				next_sreg[FLAG_N] = sum[7];
				next_sreg[FLAG_V] = sum[9];
			end
			OP_ONES_COMPLEMENT:
			begin
				next_val          = BYTE_ONES - ra_data;             // [RULE13]
				next_sreg[FLAG_Z] = (next_val == BYTE_ZERO);
				next_sreg[FLAG_C] = 1'b1;
				next_sreg[FLAG_N] = next_val[7];
				next_sreg[FLAG_V] = 1'b0;
			end
			default:
			begin
				case (op_code)
					OP_AND_REGS, OP_AND_IMM:
						next_val = ra_data & opnd_b;                 // [RULE7]
					OP_OR_REGS, OP_OR_IMM:
						next_val = ra_data | opnd_b;                 // [RULE8]
					OP_SET_MASK_BITS:
						next_val = ra_data | op_imm;                 // [RULE9]
					OP_CLEAR_MASK_BITS:
						next_val = ra_data & (BYTE_ONES - op_imm);   // [RULE10]
					OP_TEST_ZERO_MINUS:
					begin
						next_val = ra_data & ra_data;                // [RULE11]
						next_we  = 1'b0;                             // value is unchanged, skip the write
					end
					default:
						next_val = ra_data ^ ((op_code == OP_CLEAR_REG) ? ra_data : rb_data); // [RULE12]
				endcase
				next_sreg[FLAG_Z] = (next_val == BYTE_ZERO);         // [RULE7] [RULE8] [RULE9] [RULE10]
				next_sreg[FLAG_N] = next_val[7];
				next_sreg[FLAG_V] = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// execution sequencer
	// ----------------------------------------------------------------
	// fetch spends a cycle on the registered read, exec writes back;
	// pair ops add a second exec cycle for the high byte
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			ex_state <= EX_IDLE;
		end
		else
		begin
			case (ex_state)
				EX_IDLE:
				begin
					if (take && write_i && address_i == OFFS_CTRL &&
						writedata_i[OP_MSB:OP_LSB] <= OP_LAST)
					begin
						ex_state <= EX_FETCH;
					end
				end
				EX_FETCH:
					ex_state <= EX_EXEC;
				EX_EXEC:
					ex_state <= is_pair ? EX_EXEC_HI : EX_IDLE;      // [RULE2] [RULE6]
				default:
					ex_state <= EX_IDLE;
			endcase
		end
	end

	// operation latch; an unknown opcode is flagged and never run
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			op_code <= OP_ADD_REGS;
			op_rd   <= 5'h00;
			op_src  <= 5'h00;
			op_imm  <= 8'h00;
			op_bad  <= 1'b0;
		end
		else if (take && write_i && address_i == OFFS_CTRL)
		begin
			op_bad <= (writedata_i[OP_MSB:OP_LSB] > OP_LAST);
			if (writedata_i[OP_MSB:OP_LSB] <= OP_LAST)
			begin
				op_code <= bal_op_t'(writedata_i[OP_MSB:OP_LSB]);
				op_rd   <= writedata_i[RD_MSB:RD_LSB];
				op_src  <= writedata_i[SRC_MSB:SRC_LSB];
				op_imm  <= writedata_i[IMM_MSB:IMM_LSB];
			end
		end
	end

	// flags: software may preload them, e.g. the carry for a chain
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sreg <= SREG_RESET;
		end
		else if (ex_state == EX_EXEC || ex_state == EX_EXEC_HI)
		begin
			sreg <= next_sreg;
		end
		else if (take && write_i && address_i == OFFS_STATUS)
		begin
			sreg[FLAG_H:FLAG_C] <= writedata_i[FLAG_H:FLAG_C]; // spare flag bits keep their reset value
		end
	end

	// low-byte carry and zero held over for the high byte of a pair
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pair_carry   <= 1'b0;
			pair_lo_zero <= 1'b0;
			result       <= 16'h0000;
		end
		else if (ex_state == EX_EXEC)
		begin
			pair_carry   <= sum[8];
			pair_lo_zero <= (sum[7:0] == BYTE_ZERO);
			result       <= {8'h00, next_val};
		end
		else if (ex_state == EX_EXEC_HI)
		begin
			result[15:8] <= next_val;
		end
	end

	// ----------------------------------------------------------------
	// avalon slave: every access answers with waitrequest low for one
	// cycle; regfile reads take one extra cycle for the memory read
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			bus_state     <= BUS_IDLE;
			waitrequest_o <= 1'b1;
			readdata_o    <= 32'h0000_0000;
		end
		else
		begin
			case (bus_state)
				BUS_IDLE:
				begin
					if (take && read_i && in_regf)
					begin
						bus_state <= BUS_READ;
					end
					else if (take)
					begin
						bus_state     <= BUS_ACK;
						waitrequest_o <= 1'b0;
						readdata_o    <= 32'h0000_0000;             // writes and unmapped reads give zero
						if (read_i)
						begin
							if (address_i == OFFS_CTRL)
							begin
								readdata_o <= {op_imm, 3'h0, op_src, 3'h0, op_rd, 3'h0, op_code};
							end
							else if (address_i == OFFS_STATUS)
							begin
								readdata_o <= {op_bad, 23'h00_0000, sreg};
							end
							else if (address_i == OFFS_RESULT)
							begin
								readdata_o <= {16'h0000, result};
							end
						end
					end
				end
				BUS_READ:
				begin
					bus_state     <= BUS_ACK;
					waitrequest_o <= 1'b0;
					readdata_o    <= {24'h00_0000, ra_data};
				end
				default:
				begin
					bus_state     <= BUS_IDLE;
					waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

endmodule : bal_byte_alu

// ==== bal_sva.sv ====
`timescale 1ns/1ps
module bal_sva
	import bal_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [9:0]  address_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o
);
	// ----------------------------------------------------------------
	// bus answer checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic ack_rd;
	// a read answered in this cycle
	assign ack_rd = read_i && !waitrequest_o;
	property p_ack_one; !waitrequest_o |=> waitrequest_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("answer held too long");
	property p_ack_req; !waitrequest_o |-> $past(read_i) || $past(write_i); endproperty
	a_ack_req: assert property (p_ack_req) else $error("answer with no request");
	// pair ops take the longest, still well inside eight cycles
	property p_ack_bnd; (read_i || write_i) && waitrequest_o |-> ##[1:8] !waitrequest_o; endproperty
	a_ack_bnd: assert property (p_ack_bnd) else $error("request not answered");
	// an operation blocks the next answer while it executes
	property p_busy; write_i && !waitrequest_o && address_i == OFFS_CTRL |=> waitrequest_o [*2]; endproperty
	a_busy: assert property (p_busy) else $error("answer during execution");
	property p_hold; waitrequest_o |-> $stable(readdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unm; ack_rd && address_i[9:7] != REGF_PAGE && address_i > OFFS_RESULT |-> readdata_o == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_sts; ack_rd && address_i == OFFS_STATUS |-> readdata_o[30:6] == 25'h0; endproperty
	a_sts: assert property (p_sts) else $error("status spare bits set");
	property p_res; ack_rd && address_i == OFFS_RESULT |-> readdata_o[31:16] == 16'h0; endproperty
	a_res: assert property (p_res) else $error("result upper bits set");
	property p_rf; ack_rd && address_i[9:7] == REGF_PAGE |-> readdata_o[31:8] == 24'h0; endproperty
	a_rf: assert property (p_rf) else $error("register upper bits set");
endmodule : bal_sva

bind bal_byte_alu bal_sva u_sva (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i), .read_i(read_i),
	.write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o));

// ==== bal_avm_model.sv ====
`timescale 1ns/1ps
module bal_avm_model
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        go_i,
	input  wire logic        rnw_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [31:0] wd_i,
	output logic             done_o,
	output logic      [31:0] rd_o,
	output logic      [9:0]  address_o,
	output logic             read_o,
	output logic             write_o,
	output logic      [31:0] writedata_o,
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i
);
	// ----------------------------------------------------------------
	// bus master: holds everything until waitrequest is seen low
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		done_o <= 1'b0;
		if (reset_i)
		begin
			read_o <= 1'b0;
			write_o <= 1'b0;
			address_o <= 10'h000;
			writedata_o <= 32'h0;
		end
		else if ((read_o || write_o) && !waitrequest_i)
		begin
			read_o <= 1'b0;
			write_o <= 1'b0;
			rd_o <= readdata_i;
			done_o <= 1'b1;
			// released lines flip so stale values cannot pass for valid ones
			address_o <= ~address_o;
			writedata_o <= ~writedata_o;
		end
		else if (go_i && !read_o && !write_o)
		begin
			read_o <= rnw_i;
			write_o <= !rnw_i;
			address_o <= adr_i;
			writedata_o <= wd_i;
		end
	end
endmodule : bal_avm_model

// ==== test_byte_alu_arith_logic.sv ====
`timescale 1ns/1ps
module test_byte_alu_arith_logic
	import bal_pkg::*;
;
	logic        clk_i, reset_i, go, rnw, read, write, waitrequest, done, pr;
	logic [9:0]  adr, address;
	logic [31:0] wd, writedata, readdata, rq, q;
	logic [15:0] seed;
	logic [7:0]  a, b, k, h;
	logic [4:0]  rd, rs, rd2, code;
	logic [5:0]  f;
	logic [21:0] e;
	int          fail_count, check_count, p, op;

	bal_byte_alu u_dut (.clk_i(clk_i), .reset_i(reset_i), .address_i(address), .read_i(read), .write_i(write),
		.writedata_i(writedata), .readdata_o(readdata), .waitrequest_o(waitrequest));
	bal_avm_model u_mst (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .rnw_i(rnw), .adr_i(adr), .wd_i(wd),
		.done_o(done), .rd_o(rq), .address_o(address), .read_o(read), .write_o(write),
		.writedata_o(writedata), .waitrequest_i(waitrequest), .readdata_i(readdata));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic test_done();
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
			fail_count++;
		end
	endtask : chk

	// one bus access through the master model, bounded wait
	task automatic xfer(input logic r, input logic [9:0] ad, input logic [31:0] d);
		int n;
		go <= 1'b1;
		rnw <= r;
		adr <= ad;
		wd <= d;
		@(posedge clk_i);
		go <= 1'b0;
		for (n = 0; n < 40 && done !== 1'b1; n++)
			@(negedge clk_i);
		if (n >= 40)
		begin
			fail_count++;
			test_done();
		end
		q = rq;
		@(posedge clk_i);
	endtask : xfer

	function automatic logic [9:0] ra(input logic [4:0] n);
		return {REGF_PAGE, n, 2'b00};
	endfunction : ra

	function automatic logic [15:0] lf(input logic [15:0] x);
		for (int i = 0; i < 16; i++)
			x = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
		return x;
	endfunction : lf

	// expected {pair result, byte result, flags}
	function automatic logic [21:0] ref_op(input logic [4:0] o, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] k, input logic [7:0] h, input logic [5:0] f);
		logic [7:0]  x, y, r;
		logic [8:0]  s;
		logic [4:0]  l;
		logic [16:0] w;
		logic        ci, sb, ar;
		logic [5:0]  n;
		n = f;
		x = a;
		y = b;
		ci = 1'b0;
		sb = 1'b0;
		ar = 1'b1;
		r = a;
		case (o)
			5'h00: ;
			5'h01: ci = f[FLAG_C];
			5'h03: sb = 1'b1;
			5'h04: {y, sb} = {k, 1'b1};
			5'h05: {ci, sb} = {f[FLAG_C], 1'b1};
			5'h06: {y, ci, sb} = {k, f[FLAG_C], 1'b1};
			5'h0E: {x, y, sb} = {8'h00, a, 1'b1};
			5'h11: y = 8'h01;
			5'h12: {y, sb} = {8'h01, 1'b1};
			default: ar = 1'b0;
		endcase
		if (o == 5'h02 || o == 5'h07)
		begin
			w = (o == 5'h07) ? {1'b0, h, a} - {9'h0, k} : {1'b0, h, a} + {9'h0, k};
			n[FLAG_C] = w[16];
			n[FLAG_V] = (o == 5'h07) ? (h[7] & ~w[15]) : (~h[7] & w[15]);
			n[FLAG_N] = w[15];
			n[FLAG_S] = w[15] ^ n[FLAG_V];
			n[FLAG_Z] = (w[15:0] == 16'h0);
			return {w[15:0], n};
		end
		if (ar)
		begin
			s = sb ? {1'b0, x} - {1'b0, y} - {8'h0, ci} : {1'b0, x} + {1'b0, y} + {8'h0, ci};
			l = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci} : {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
			r = s[7:0];
			n[FLAG_V] = (x[7] ^ y[7] ^ ~sb) & (r[7] ^ x[7]);
			// increment and decrement leave carry and half carry alone
			if (o < 5'h11)
				{n[FLAG_C], n[FLAG_H]} = {s[8], l[4]};
		end
		else
		begin
			case (o)
				5'h08: r = a & b;
				5'h09: r = a & k;
				5'h0A: r = a | b;
				5'h0B, 5'h0F: r = a | k;
				5'h0C: r = a ^ b;
				5'h0D: r = ~a;
				5'h10: r = a & ~k;
				5'h14: r = 8'h00;
				default: ;
			endcase
			n[FLAG_V] = 1'b0;
			if (o == 5'h0D)
				n[FLAG_C] = 1'b1;
		end
		n[FLAG_Z] = (r == 8'h00);
		n[FLAG_N] = r[7];
		return {8'h00, r, n};
	endfunction : ref_op

	// ----------------------------------------------------------------
	// main sequence: two corner passes, then random operands
	// ----------------------------------------------------------------
	initial
	begin
		fail_count = 0;
		check_count = 0;
		go = 1'b0;
		rnw = 1'b1;
		adr = 10'h000;
		wd = 32'h0;
		seed = 16'h000A;
		reset_i = 1'b1;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		xfer(1'b1, OFFS_STATUS, 32'h0);
		chk(q, 32'h0);
		xfer(1'b0, 10'h00C, 32'hFFFFFFFF);
		xfer(1'b1, 10'h00C, 32'h0);
		chk(q, 32'h0);
		for (p = 0; p < 4; p++)
			for (op = 0; op < 22; op++)
			begin
				seed = lf(seed);
				{a, b} = seed;
				seed = lf(seed);
				{k, h} = seed;
				seed = lf(seed);
				{f, rs, rd} = seed;
				if (p == 0)
					{a, b, k, h} = 32'h7F01017F;
				if (p == 1)
					{a, b, k, h} = 32'h0080FF00;
				pr = (op == 2 || op == 7);
				rd2 = pr ? {rd[4:1], 1'b0} : rd;
				xfer(1'b0, ra(rs), {24'h0, b});
				if (pr)
					xfer(1'b0, ra({rd[4:1], 1'b1}), {24'h0, h});
				xfer(1'b0, ra(rd2), {24'h0, a});
				if (rs == rd2)
					b = a;
				// spare flag bits are written as ones and must still read back as zero
				xfer(1'b0, OFFS_STATUS, {24'h0, 2'b11, f});
				code = (op < 21) ? op[4:0] : (5'h15 | {1'b0, seed[3:0]});
				xfer(1'b0, OFFS_CTRL, {k, 3'h0, rs, 3'h0, rd, 3'h0, code});
				e = (op < 21) ? ref_op(code, a, b, k, h, f) : {8'h00, a, f};
				xfer(1'b1, OFFS_STATUS, 32'h0);
				chk(q, {op == 21, 25'h0, e[5:0]});
				xfer(1'b1, ra(rd2), 32'h0);
				chk(q, {24'h0, e[13:6]});
				if (pr)
				begin
					xfer(1'b1, ra({rd[4:1], 1'b1}), 32'h0);
					chk(q, {24'h0, e[21:14]});
				end
				// result and the latched control word hold for every valid operation
				if (op < 21)
				begin
					xfer(1'b1, OFFS_RESULT, 32'h0);
					chk(q, {16'h0, e[21:6]});
					xfer(1'b1, OFFS_CTRL, 32'h0);
					chk(q, {k, 3'h0, rs, 3'h0, rd, 3'h0, code});
				end
			end
		test_done();
	end
endmodule : test_byte_alu_arith_logic
